// ---- hw/port_expander_regs.vh ----
// Constants for the sixteen-bit serial port expander.
`ifndef PORT_EXPANDER_REGS_VH
`define PORT_EXPANDER_REGS_VH
// ****************************************
// Bus address and framing
// ****************************************
`define ADDR_FIXED_HI 4'h4
`define ADDR_LOW_W 3
`define BIT_CNT_LAST 4'h7
`define BIT_CNT_ACK 4'h8
`define BIT_CNT_ZERO 4'h0
`define PORT_W 16
`define PORT_ALL_ONES 16'hFFFF
`define PORT_ALL_ZERO 16'h0000
`define BYTE_ZERO 8'h00
// ****************************************
// Read bit positions
// ****************************************
`define LO_MSB 7
`define HI_MSB 15
`define LO_NEXT_TOP 6
`define HI_NEXT_TOP 14
// ****************************************
// Interrupt timing
// ****************************************
`define IRQ_VALID_DELAY_NS 4000
`define CLK_PERIOD_NS 40
`define IRQ_VALID_CYCLES ((`IRQ_VALID_DELAY_NS) / (`CLK_PERIOD_NS))
`define IRQ_CNT_W 8
`define CLR_HOLD_CYCLES 2'h3
`define CLR_HOLD_ZERO 2'h0
`endif

// ---- hw/pin_sync.v ----
// Two-stage synchroniser for a group of pins from outside the clock's domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b1}}
) (
	// Clock and reset.
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// Pins in and synchronised levels out.
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_q;

	// Only the second stage is read outside this module.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ---- hw/port_expander.v ----
// Sixteen-bit quasi-bidirectional port expander behind a serial two-wire slave.
// Notes on behaviour
// - Sixteen port pins, each input or output, with no direction register.
// - After reset all port pins are undriven.
// - Writing a pin high pulses a strong pull-up until next clock falling edge.
// - Any input pin edge asserts the active-low interrupt after a set delay.
// - Interrupt clears when pins return to snapshot, or on port read or write.
// - Clear happens in the acknowledge bit: read after rise, write after fall.
// - Pin changes during the acknowledge pulse may be lost or very short.
// - Later changes re-assert interrupt; traffic to other slaves has no effect.
// - Data moves in byte pairs, low half first then high half.
// - Write bytes are acknowledged; pair shows on pins after second acknowledge.
// - Unlimited pairs per write, each replacing the port value.
// - Read returns sampled pin values; fast changes may be missed.
// - Reset holds the block; release returns the bus machine to idle.
// - Three select inputs give the low address bits, eight devices per bus.
// - Answers addresses 0x20 to 0x27, select bits most significant first.
// - General call ignored; only a matching address is acknowledged.
// - A stop mid-pair keeps the port value from the last full pair.
`timescale 1ns/1ps
`default_nettype none
`include "port_expander_regs.vh"
module port_expander (
	// Clock, reset and clock enable.
	input wire ref_clk,
	input wire sys_rst,
	input wire clk_en,
	// Serial bus, open drain on the data line.
	input wire scl_in,
	input wire sda_in,
	output reg sda_oe,
	// Address select straps.
	input wire addr_sel_bit0,
	input wire addr_sel_bit1,
	input wire addr_sel_bit2,
	// Port pins: low drive enable and strong pull-up enable per pin.
	input wire [15:0] port_in,
	output reg [15:0] port_pull_low,
	output reg [15:0] port_pull_high,
	// Interrupt, open drain, active low; high enable means pin pulled low.
	output reg irq_n_oe
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	wire scl_s;
	wire sda_s;
	wire [2:0] sel_s;
	wire [15:0] pin_s;

	pin_sync #(.W(2), .INIT(2'h3)) u_bus_sync (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.async_in({scl_in, sda_in}), .sync_out({scl_s, sda_s}));
	pin_sync #(.W(3), .INIT(3'h0)) u_sel_sync (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.async_in({addr_sel_bit2, addr_sel_bit1, addr_sel_bit0}), .sync_out(sel_s));
	pin_sync #(.W(16), .INIT(16'hFFFF)) u_pin_sync (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.async_in(port_in), .sync_out(pin_s));

	// ****************************************
	// Edge and condition detection
	// ****************************************
	reg scl_q;
	reg sda_q;
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_c = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_c = scl_s & scl_q & ~sda_q & sda_s;

	// Registered copies of the synchronised lines; idle high so reset makes no false edge.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (clk_en) begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// ****************************************
	// Serial slave state machine
	// ****************************************
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ADDR = 5'h02;
	localparam [4:0] ST_WR = 5'h04;
	localparam [4:0] ST_RD = 5'h08;
	localparam [4:0] ST_RACK = 5'h10;

	reg [4:0] state_q;
	reg [3:0] bit_q;
	reg [7:0] shift_q;
	reg [7:0] low_byte_q;
	reg high_sel_q;
	reg [15:0] port_q;
	reg [15:0] rd_q;
	reg ack_q;
	reg clr_q;
	wire [6:0] my_addr = {`ADDR_FIXED_HI, sel_s};
	wire [7:0] shifted = {shift_q[6:0], sda_s};

	// Byte pointer picks the half: pairs alternate low then high.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			bit_q <= `BIT_CNT_ZERO;
			shift_q <= `BYTE_ZERO;
			low_byte_q <= `BYTE_ZERO;
			high_sel_q <= 1'b0;
			port_q <= `PORT_ALL_ONES;
			port_pull_high <= `PORT_ALL_ZERO;
			rd_q <= `PORT_ALL_ONES;
			ack_q <= 1'b0;
			sda_oe <= 1'b0;
			clr_q <= 1'b0;
		end else if (clk_en) begin
			clr_q <= 1'b0;
			// Strong pull-up ends on any clock falling edge.
			if (scl_fall)
				port_pull_high <= `PORT_ALL_ZERO;
			if (stop_c) begin
				state_q <= ST_IDLE;
				sda_oe <= 1'b0;
				ack_q <= 1'b0;
			end else if (start_c) begin
				state_q <= ST_ADDR;
				bit_q <= `BIT_CNT_ZERO;
				sda_oe <= 1'b0;
				ack_q <= 1'b0;
				high_sel_q <= 1'b0;
			end else begin
				case (state_q)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_ADDR, ST_WR: begin
					if (scl_rise && bit_q <= `BIT_CNT_LAST) begin
						shift_q <= shifted;
						bit_q <= bit_q + 4'h1;
					end
					if (scl_fall && bit_q == `BIT_CNT_ACK && !ack_q) begin
						if (state_q == ST_ADDR) begin
							if (shift_q[7:1] == my_addr) begin
								ack_q <= 1'b1;
								sda_oe <= 1'b1;
							end else
								state_q <= ST_IDLE;
						end else begin
							ack_q <= 1'b1;
							sda_oe <= 1'b1;
						end
					end else if (scl_fall && ack_q) begin
						ack_q <= 1'b0;
						sda_oe <= 1'b0;
						bit_q <= `BIT_CNT_ZERO;
						if (state_q == ST_ADDR) begin
							rd_q <= pin_s;
							if (shift_q[0]) begin
								state_q <= ST_RD;
								sda_oe <= ~pin_s[`LO_MSB];
							end else
								state_q <= ST_WR;
						end else begin
							clr_q <= 1'b1;
							if (high_sel_q) begin
								port_q <= {shift_q, low_byte_q};
								port_pull_high <= {shift_q, low_byte_q};
							end else
								low_byte_q <= shift_q;
							high_sel_q <= ~high_sel_q;
						end
					end
				end
				ST_RD: begin
					// Bits leave MSB first; next bit is set after each fall.
					if (scl_fall) begin
						if (bit_q == `BIT_CNT_LAST) begin
							sda_oe <= 1'b0;
							state_q <= ST_RACK;
						end else begin
							sda_oe <= high_sel_q ?
								~rd_q[`HI_NEXT_TOP - bit_q[2:0]] :
								~rd_q[`LO_NEXT_TOP - bit_q[2:0]];
						end
						bit_q <= bit_q + 4'h1;
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						clr_q <= 1'b1;
						if (sda_s)
							state_q <= ST_IDLE;
					end else if (scl_fall) begin
						bit_q <= `BIT_CNT_ZERO;
						state_q <= ST_RD;
						if (high_sel_q)
							rd_q <= pin_s;
						high_sel_q <= ~high_sel_q;
						sda_oe <= high_sel_q ? ~pin_s[`LO_MSB] : ~rd_q[`HI_MSB];
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// Quasi-bidirectional pins: a zero drives low, a one is left weak.
	always @(posedge ref_clk) begin
		if (sys_rst)
			port_pull_low <= `PORT_ALL_ZERO;
		else if (clk_en)
			port_pull_low <= ~port_q;
	end

	// ****************************************
	// Change detect interrupt
	// ****************************************
	// The snapshot is retaken at each clear, so a change inside the
	// acknowledge pulse is absorbed: the cost of clearing there.
	reg [15:0] snap_q;
	reg [`IRQ_CNT_W-1:0] dly_q;
	reg [1:0] clr_hold_q;
	wire differs = |(pin_s ^ snap_q);

	// A written value needs a few cycles to come back through the pin synchroniser,
	// so the snapshot is retaken for that long; otherwise every write would interrupt.
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			snap_q <= `PORT_ALL_ONES;
			dly_q <= {`IRQ_CNT_W{1'b0}};
			irq_n_oe <= 1'b0;
			clr_hold_q <= `CLR_HOLD_ZERO;
		end else if (clk_en) begin
			if (clr_q || clr_hold_q != `CLR_HOLD_ZERO) begin
				snap_q <= pin_s;
				dly_q <= {`IRQ_CNT_W{1'b0}};
				irq_n_oe <= 1'b0;
				clr_hold_q <= clr_q ? `CLR_HOLD_CYCLES : clr_hold_q - 2'h1;
			end else if (!differs) begin
				dly_q <= {`IRQ_CNT_W{1'b0}};
				irq_n_oe <= 1'b0;
			end else if (dly_q >= `IRQ_VALID_CYCLES - 1) begin
				irq_n_oe <= 1'b1;
			end else
				dly_q <= dly_q + 1'b1;
		end
	end
endmodule // port_expander
`default_nettype wire

// ---- verification/bus_master_model.sv ----
// Serial bus master model that clocks the expander's two lines.
`timescale 1ns/1ps
`default_nettype none
module bus_master (
	// Clock and resolved data line.
	input wire logic ref_clk,
	input wire logic sda,
	// Driven lines; a high sda_low pulls data down.
	output logic scl,
	output logic sda_low
);
	// Both lines start released so the bus is idle at time zero.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// ****
	// Line changes fall on system clock falling edges only.
	// ****
	task automatic gap(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// One 320 ns bit; data moves a cycle after the fall so it never looks like a start.
	task automatic bit_io(input logic b, output logic r);
		gap(1);
		sda_low = !b;
		gap(3);
		scl = 1'b1;
		gap(2);
		r = sda;
		gap(2);
		scl = 1'b0;
	endtask
	task automatic start();
		sda_low = 1'b1;
		gap(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		gap(1);
		sda_low = 1'b1;
		gap(3);
		scl = 1'b1;
		gap(4);
		sda_low = 1'b0;
		gap(4);
	endtask
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// A high nack ends a read so the device lets go of the data line.
	task automatic byte_in(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule // bus_master
`default_nettype wire

// ---- verification/port_expander_properties.sv ----
// Checker for the expander's pull, acknowledge and interrupt timing.
`timescale 1ns/1ps
`default_nettype none
module port_expander_properties (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Watched ports.
	input wire logic scl_in,
	input wire logic [15:0] port_in,
	input wire logic sda_oe,
	input wire logic [15:0] port_pull_low,
	input wire logic [15:0] port_pull_high,
	input wire logic irq_n_oe
);
	logic [15:0] pin_q;
	logic [7:0] quiet_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Cycles since the pins last moved; it saturates so a long quiet spell never wraps.
	always_ff @(posedge ref_clk) begin
		pin_q <= port_in;
		if (sys_rst || port_in != pin_q) begin
			quiet_q <= 8'h00;
		end else if (quiet_q != 8'hFF) begin
			quiet_q <= quiet_q + 8'h01;
		end
	end
	sequence s_pull_on;
		$rose(|port_pull_high);
	endsequence
	a_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
		!sda_oe && !irq_n_oe && port_pull_low == 16'h0000 && port_pull_high == 16'h0000)
		else $error("outputs not idle after reset");
	a_pullup_drop: assert property (|port_pull_high && $fell(scl_in) |->
		##[1:6] port_pull_high == 16'h0000) else $error("pull-up outlived clock fall");
	a_pullup_at_ack: assert property (s_pull_on |-> $past(sda_oe) || $past(sda_oe, 2))
		else $error("pull-up outside acknowledge");
	a_pull_match: assert property (s_pull_on |=> port_pull_high == ~port_pull_low)
		else $error("pull-up bits differ from written ones");
	a_pins_at_ack: assert property ($changed(port_pull_low) |->
		$past(sda_oe) || $past(sda_oe, 2) || $past(sda_oe, 3)) else $error("pins moved off ack");
	a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*6])
		else $error("acknowledge too short");
	a_irq_cause: assert property ($rose(irq_n_oe) |-> quiet_q < 8'hC8)
		else $error("interrupt without pin change");
	a_irq_delay: assert property ($changed(port_in) && !irq_n_oe |=> !irq_n_oe [*8])
		else $error("interrupt before its delay");
endmodule // port_expander_properties
bind port_expander port_expander_properties u_props (.ref_clk, .sys_rst, .scl_in, .port_in,
	.sda_oe, .port_pull_low, .port_pull_high, .irq_n_oe);
`default_nettype wire

// ---- verification/port_expander_bench.sv ----
// Self-checking bench for the port expander.
`timescale 1ns/1ps
`default_nettype none
module port_expander_bench;
	logic ref_clk = 1'b0;
	logic sys_rst;
	logic clk_en;
	logic [2:0] sel;
	logic [15:0] ext = 16'hFFFF;
	logic scl_in, sda_low, sda_oe, irq_n_oe, a;
	logic [15:0] port_pull_low, port_pull_high;
	int err_total = 0;
	int compares = 0;
	// Both lines have pull-ups; a pin reads low wherever the device pulls it.
	wire logic sda_in = !(sda_low || sda_oe);
	wire logic [15:0] port_in = ext & ~port_pull_low;
	always #20 ref_clk = ~ref_clk;
	port_expander u_dut (.ref_clk, .sys_rst, .clk_en, .scl_in, .sda_in, .sda_oe,
		.addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]),
		.port_in, .port_pull_low, .port_pull_high, .irq_n_oe);
	bus_master m (.ref_clk, .sda(sda_in), .scl(scl_in), .sda_low);
	// ****
	// Checks and bus helpers
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic put(input logic [7:0] d, input logic ack);
		m.byte_out(d, a);
		chk({15'h0, a}, {15'h0, ack});
	endtask
	task automatic irq_is(input logic v);
		chk({15'h0, irq_n_oe}, {15'h0, v});
	endtask
	task automatic rd(input logic [15:0] exp);
		logic [7:0] lo, hi;
		m.start();
		put({4'h4, sel, 1'b1}, 1'b1);
		m.byte_in(1'b0, lo);
		m.byte_in(1'b1, hi);
		m.stop();
		chk({hi, lo}, exp);
	endtask
	task automatic t_reset();
		m.gap(4);
		chk(port_pull_low, 16'h0000);
		chk(port_pull_high, 16'h0000);
		irq_is(1'b0);
		$display("reset test done");
	endtask
	// Two pairs then a lone byte; the lone byte must never reach the pins.
	task automatic t_write();
		m.start();
		put({4'h4, sel, 1'b0}, 1'b1);
		put(8'hAA, 1'b1);
		put(8'h55, 1'b1);
		m.gap(6);
		chk(port_pull_low, 16'hAA55);
		chk(port_pull_high, 16'h55AA);
		put(8'h0F, 1'b1);
		put(8'hF0, 1'b1);
		put(8'hC3, 1'b1);
		m.stop();
		chk(port_pull_low, 16'h0FF0);
		m.gap(120);
		irq_is(1'b0);
		$display("write test done");
	endtask
	task automatic t_addr();
		for (int s = 0; s < 8; s++) begin
			sel = s[2:0];
			m.gap(4);
			m.start();
			put({4'h4, s[2:0], 1'b0}, 1'b1);
			m.stop();
			m.start();
			put({4'h4, s[2:0] + 3'h1, 1'b0}, 1'b0);
			m.stop();
		end
		m.start();
		put(8'h00, 1'b0);
		m.stop();
		sel = 3'h5;
		$display("address test done");
	endtask
	task automatic t_irq();
		m.gap(4);
		m.start();
		put({4'h4, sel, 1'b0}, 1'b1);
		put(8'hFF, 1'b1);
		put(8'hFF, 1'b1);
		m.stop();
		rd(16'hFFFF);
		ext = 16'h3C5A;
		m.gap(150);
		irq_is(1'b1);
		m.start();
		put({4'h4, sel + 3'h1, 1'b0}, 1'b0);
		m.stop();
		irq_is(1'b1);
		rd(16'h3C5A);
		irq_is(1'b0);
		ext = 16'hFFFF;
		m.gap(150);
		irq_is(1'b1);
		// A low clock enable must hold the interrupt although the pins went back.
		clk_en = 1'b0;
		ext = 16'h3C5A;
		m.gap(20);
		irq_is(1'b1);
		clk_en = 1'b1;
		m.gap(20);
		irq_is(1'b0);
		$display("interrupt test done");
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		sel = 3'h5;
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		t_reset();
		t_write();
		t_addr();
		t_irq();
		tally_and_finish();
	end
	// The tests need about 3250 cycles; a hang is cut off well past that.
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		tally_and_finish();
	end
endmodule // port_expander_bench
`default_nettype wire
